// File: common/dma_ctrl_pkg.sv
// shared constants and types for the mac dma control block
package dma_ctrl_pkg;
  localparam logic [7:0] OFF_TXC = 8'h00;
  localparam logic [7:0] OFF_RXC = 8'h04;
  localparam int TX_DMA_EN_BIT = 0;
  localparam int TX_CRC_BIT = 1;
  localparam int TX_PAD_BIT = 2;
  localparam int TX_FC_BIT = 9;
  localparam int TX_IPCS_BIT = 16;
  localparam int TX_TCPCS_BIT = 17;
  localparam int TX_UDPCS_BIT = 18;
  localparam int BURST_LSB = 24;
  localparam int BURST_W = 6;
  localparam int RX_ALIGN_BIT = 19;
  localparam logic [31:0] TXC_WMASK = 32'h3F07_0207;
  localparam logic [31:0] RXC_WMASK = 32'h3F08_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int MIN_FRAME_BYTES = 64;
  localparam int CRC_BYTES = 4;
  localparam int PAD_TO_WORDS = (MIN_FRAME_BYTES - CRC_BYTES) / 4;
  localparam int ALIGN_SHIFT_BYTES = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 34;
  localparam int FC_HIGH_WATER = 24;

  // one word of frame data with its markers
  typedef struct packed {
    logic sof;
    logic eof;
    logic [31:0] data;
  } word_t;

  // transmit frame options handed to the framer
  typedef struct packed {
    logic ip_csum;
    logic tcp_csum;
    logic udp_csum;
    logic pad;
    logic crc;
  } tx_opts_t;
endpackage : dma_ctrl_pkg

// File: src/mac_dma_txrx_control.sv
// mac dma transmit/receive control registers and data paths
//
// Functional notes
// - ip checksum gen bit inserts correct ip header checksum on transmit.
// - flow control in full duplex sends pause when rx buffer fills.
// - flow control in half duplex uses back-pressure instead.
// - flow control enable clear means no transmit flow control at all.
// - padding enable extends short frames to 64 bytes.
// - padding enable forces crc append on.
// - crc append bit attaches frame crc at end.
// - setting tx dma enable starts the transmit process running.
// - clearing enable stops transmit only after current frame ends.
// - stop honoured only while running.
// - rx burst size limits words per receive bus transaction.
// - rx burst size zero means no word limit; a transaction then ends only at frame end.
// - ip alignment shifts rx frame two bytes and reports it.
// - alignment bit clear stores frames unshifted.
// - tx burst size is only reported on O_TX_BURST_LEN; it does not limit transmit words.
// - udp and tcp checksum generation bits exist in tx control.
`timescale 1ns/1ps
module mac_dma_txrx_control
  import dma_ctrl_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // register port
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [3:0] I_REG_BE,
  input wire logic [31:0] I_REG_WDATA,
  output logic [31:0] O_REG_RDATA,
  // host transmit words
  input wire logic [31:0] I_TX_DATA,
  input wire logic I_TX_SOF,
  input wire logic I_TX_EOF,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  // mac transmit side
  output logic [31:0] O_MAC_TX_DATA,
  output logic O_MAC_TX_SOF,
  output logic O_MAC_TX_EOF,
  output logic O_MAC_TX_VALID,
  input wire logic I_MAC_TX_READY,
  input wire logic I_FULL_DUPLEX,
  output logic O_PAUSE_REQ,
  output logic O_BACKPRESSURE,
  output logic O_TX_RUNNING,
  // mac receive side
  input wire logic [31:0] I_MAC_RX_DATA,
  input wire logic I_MAC_RX_SOF,
  input wire logic I_MAC_RX_EOF,
  input wire logic I_MAC_RX_VALID,
  output logic O_MAC_RX_READY,
  // host receive words
  output logic [31:0] O_RX_DATA,
  output logic O_RX_SOF,
  output logic O_RX_EOF,
  output logic O_RX_VALID,
  output logic O_RX_SHIFTED,
  output logic O_RX_BURST_END,
  input wire logic I_RX_READY,
  output logic [5:0] O_TX_BURST_LEN
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] txc_q;
  logic [31:0] rxc_q;
  typedef enum logic [1:0] {STOPPED, RUNNING, STOPPING} txst_t;
  txst_t txst_q;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] be,
                                           input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r & msk;
  endfunction : be_merge

  wire sel_txc = (I_REG_ADDR == OFF_TXC);
  wire sel_rxc = (I_REG_ADDR == OFF_RXC);
  wire [31:0] txc_d = be_merge(txc_q, I_REG_WDATA, I_REG_BE, TXC_WMASK);
  wire [31:0] rxc_d = be_merge(rxc_q, I_REG_WDATA, I_REG_BE, RXC_WMASK);
  wire [31:0] rd_d = sel_txc ? txc_q : (sel_rxc ? rxc_q : 32'h0000_0000);

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      txc_q <= REG_RESET;
      rxc_q <= REG_RESET;
      O_REG_RDATA <= 32'h0000_0000;
    end else begin
      if (I_REG_WR && sel_txc) txc_q <= txc_d;
      if (I_REG_WR && sel_rxc) rxc_q <= rxc_d;
      if (I_REG_RD) O_REG_RDATA <= rd_d;
    end
  end

  wire tx_en = txc_q[TX_DMA_EN_BIT];
  wire fc_en = txc_q[TX_FC_BIT];
  wire [5:0] tx_burst = txc_q[BURST_LSB +: BURST_W];
  wire [5:0] rx_burst = rxc_q[BURST_LSB +: BURST_W];
  wire align_en = rxc_q[RX_ALIGN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // transmit process state
  word_t fr_out;
  logic fr_valid;
  logic fr_ready;
  logic fr_done;
  logic in_frame_q;
  wire mac_take = fr_valid && I_MAC_TX_READY;
  wire frame_end = mac_take && fr_done;
  wire frame_start = mac_take && fr_out.sof;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      txst_q <= STOPPED;
      in_frame_q <= 1'b0;
    end else begin
      if (frame_end) in_frame_q <= 1'b0;
      else if (frame_start) in_frame_q <= 1'b1;
      case (txst_q)
        STOPPED: if (tx_en) txst_q <= RUNNING;
        RUNNING: if (!tx_en) txst_q <= (in_frame_q && !frame_end) ?
                                       STOPPING : STOPPED;
        STOPPING: if (frame_end || !in_frame_q) txst_q <= STOPPED;
        default: txst_q <= STOPPED;
      endcase
    end
  end

  // new frames start only while running; a frame in flight drains
  wire tx_gate = (txst_q == RUNNING) || in_frame_q;
  tx_opts_t opts;
  assign opts.ip_csum = txc_q[TX_IPCS_BIT];
  // l4 checksum bits kept for the framer
  assign opts.tcp_csum = txc_q[TX_TCPCS_BIT];
  assign opts.udp_csum = txc_q[TX_UDPCS_BIT];
  assign opts.pad = txc_q[TX_PAD_BIT];
  assign opts.crc = txc_q[TX_CRC_BIT];

  word_t tx_in;
  assign tx_in.sof = I_TX_SOF;
  assign tx_in.eof = I_TX_EOF;
  assign tx_in.data = I_TX_DATA;
  logic fr_in_ready;

  tx_framer u_framer (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_opts(opts),
    .i_word(tx_in),
    .i_valid(I_TX_VALID && tx_gate),
    .o_ready(fr_in_ready),
    .o_word(fr_out),
    .o_valid(fr_valid),
    .i_ready(fr_ready),
    .o_frame_done(fr_done)
  );
  assign fr_ready = I_MAC_TX_READY;

  ////////////////////////////////////////////////////////////////////////
  // receive fifo and flow control
  logic [FIFO_WIDTH-1:0] rxf_out;
  logic rxf_valid;
  logic rxf_in_ready;
  logic rxf_pop;
  logic [5:0] rxf_count;
  logic [31:0] rx_word_d;
  logic rx_sof_d;
  logic rx_eof_d;

  // shift by two bytes when aligning
  logic [15:0] carry_q;
  logic tail_q;
  wire [31:0] shifted = {I_MAC_RX_DATA[15:0], carry_q};
  wire [31:0] rx_w = align_en ? shifted : I_MAC_RX_DATA;
  wire rx_push = (I_MAC_RX_VALID || tail_q) && rxf_in_ready;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      carry_q <= '0;
      tail_q <= 1'b0;
    end else if (rx_push) begin
      carry_q <= I_MAC_RX_DATA[31:16];
      tail_q <= align_en && I_MAC_RX_VALID && I_MAC_RX_EOF;
    end
  end

  // a tail word flushes the last two bytes when aligning
  wire [31:0] push_w = tail_q ? {16'h0000, carry_q} :
                       (align_en && I_MAC_RX_SOF ?
                        {I_MAC_RX_DATA[15:0], 16'h0000} : rx_w);
  wire push_eof = tail_q || (I_MAC_RX_EOF && !align_en);
  wire push_sof = !tail_q && I_MAC_RX_SOF;

  word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rxfifo (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_data({push_sof, push_eof, push_w}),
    .i_valid(I_MAC_RX_VALID || tail_q),
    .o_ready(rxf_in_ready),
    .o_data(rxf_out),
    .o_valid(rxf_valid),
    .i_ready(rxf_pop),
    .o_count(rxf_count)
  );

  wire hi_water = fc_en && (rxf_count >= 6'(FC_HIGH_WATER));
  wire pause_d = hi_water && I_FULL_DUPLEX;
  wire bp_d = hi_water && !I_FULL_DUPLEX;

  ////////////////////////////////////////////////////////////////////////
  // receive burst limiting
  logic [5:0] rx_beat_q;
  logic burst_end_q;
  wire burst_last = (rx_burst != 6'd0) && (rx_beat_q + 6'd1 >= rx_burst);
  wire out_busy = O_RX_VALID && !I_RX_READY;
  assign rxf_pop = rxf_valid && !out_busy && !burst_end_q;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rx_beat_q <= '0;
      burst_end_q <= 1'b0;
      O_RX_DATA <= '0;
      O_RX_SOF <= 1'b0;
      O_RX_EOF <= 1'b0;
      O_RX_VALID <= 1'b0;
      O_RX_SHIFTED <= 1'b0;
      O_RX_BURST_END <= 1'b0;
    end else begin
      // one idle cycle between bursts ends the bus transaction
      burst_end_q <= rxf_pop && (burst_last || !rxf_valid);
      if (rxf_pop) begin
        // a frame end also closes the transaction
        rx_beat_q <= (burst_last || rxf_out[32]) ? 6'd0 : rx_beat_q + 6'd1;
        O_RX_DATA <= rxf_out[31:0];
        O_RX_EOF <= rxf_out[32];
        O_RX_SOF <= rxf_out[33];
        O_RX_SHIFTED <= align_en;
        O_RX_BURST_END <= burst_last || rxf_out[32];
        O_RX_VALID <= 1'b1;
      end else if (!out_busy) begin
        O_RX_VALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_PAUSE_REQ <= 1'b0;
      O_BACKPRESSURE <= 1'b0;
      O_TX_RUNNING <= 1'b0;
      O_TX_BURST_LEN <= '0;
      O_MAC_RX_READY <= 1'b0;
    end else begin
      O_PAUSE_REQ <= pause_d;
      O_BACKPRESSURE <= bp_d;
      O_TX_RUNNING <= (txst_q != STOPPED);
      O_TX_BURST_LEN <= tx_burst;
      O_MAC_RX_READY <= rxf_in_ready && !tail_q;
    end
  end

  assign O_TX_READY = fr_in_ready && tx_gate;
  assign O_MAC_TX_DATA = fr_out.data;
  assign O_MAC_TX_SOF = fr_out.sof;
  assign O_MAC_TX_EOF = fr_out.eof;
  assign O_MAC_TX_VALID = fr_valid;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_tx_start: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (txst_q == STOPPED && tx_en) |=> txst_q == RUNNING)
    else $error("tx did not start");
  a_tx_drain: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (txst_q == STOPPING && !frame_end && in_frame_q) |=> txst_q != STOPPED)
    else $error("tx stopped mid frame");
  a_fc_off: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    !fc_en |=> !O_PAUSE_REQ && !O_BACKPRESSURE)
    else $error("flow control while disabled");
  a_pause_fd: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    pause_d |=> O_PAUSE_REQ && !O_BACKPRESSURE)
    else $error("pause missing");
  a_bp_hd: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    bp_d |=> O_BACKPRESSURE && !O_PAUSE_REQ)
    else $error("backpressure missing");
  a_rx_burst: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (rxf_pop && burst_last) |=> !rxf_pop)
    else $error("burst overrun");
  a_stop_only: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (txst_q == STOPPED) |=> txst_q != STOPPING)
    else $error("stop outside running");
  a_tx_burst: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    ##1 O_TX_BURST_LEN == $past(tx_burst))
    else $error("tx burst len mismatch");
endmodule : mac_dma_txrx_control

// File: src/tx_framer.sv
// transmit framer: checksum fixup, padding and crc append
`timescale 1ns/1ps
module tx_framer
  import dma_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire tx_opts_t i_opts,
  input wire word_t i_word,
  input wire logic i_valid,
  output logic o_ready,
  output word_t o_word,
  output logic o_valid,
  input wire logic i_ready,
  output logic o_frame_done
);
  typedef enum logic [1:0] {PASS, PAD, CRC} fstate_t;
  fstate_t st_q;
  logic [5:0] wcnt_q;
  logic [31:0] crc_q;
  logic [15:0] ipsum_q;

  function automatic logic [31:0] crc_word(input logic [31:0] c,
                                           input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 32; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hEDB8_8320) : (r >> 1);
    end
    return r;
  endfunction : crc_word

  // checksum is a ones complement fold over header words 3..7
  wire in_ip_hdr = (wcnt_q >= 6'd3) && (wcnt_q <= 6'd7);
  wire [16:0] s1 = {1'b0, ipsum_q} + {1'b0, i_word.data[31:16]};
  wire [15:0] f1 = s1[15:0] + {15'h0000, s1[16]};
  wire [16:0] s2 = {1'b0, f1} + {1'b0, i_word.data[15:0]};
  wire [15:0] f2 = s2[15:0] + {15'h0000, s2[16]};
  // the csum slot in header word 7 carries zero from the host
  wire [31:0] fixed = (i_opts.ip_csum && wcnt_q == 6'd7) ?
                      {i_word.data[31:16], ~f2} : i_word.data;
  wire crc_on = i_opts.crc || i_opts.pad;
  wire short = (wcnt_q + 6'd1) < 6'(PAD_TO_WORDS);
  wire [31:0] out_d = (st_q == PASS) ? fixed :
                      (st_q == PAD) ? 32'h0000_0000 : ~crc_q;

  // input only moves when the mac takes the word
  assign o_ready = (st_q == PASS) && i_ready;
  assign o_valid = (st_q == PASS) ? i_valid : 1'b1;
  assign o_word.data = out_d;
  assign o_word.sof = (st_q == PASS) && i_word.sof;
  assign o_word.eof = (st_q == CRC) ||
    (st_q == PASS && i_word.eof && !crc_on && !(i_opts.pad && short)) ||
    (st_q == PAD && !crc_on);
  assign o_frame_done = o_valid && o_word.eof;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= PASS;
      wcnt_q <= '0;
      crc_q <= 32'hFFFF_FFFF;
      ipsum_q <= '0;
    end else if (o_valid && i_ready) begin
      // crc taken over the fixed-up and padded content
      crc_q <= (st_q == CRC) ? 32'hFFFF_FFFF : crc_word(crc_q, out_d);
      wcnt_q <= (o_word.eof) ? '0 : (wcnt_q == 6'h3F ? wcnt_q : wcnt_q + 6'd1);
      ipsum_q <= (st_q == PASS && in_ip_hdr) ? f2 :
                 (o_word.eof ? 16'h0000 : ipsum_q);
      case (st_q)
        PASS: if (i_word.eof) begin
          if (i_opts.pad && short) st_q <= PAD;
          else if (crc_on) st_q <= CRC;
        end
        PAD: if (!short) st_q <= crc_on ? CRC : PASS;
        CRC: st_q <= PASS;
        default: st_q <= PASS;
      endcase
    end
  end
endmodule : tx_framer

// File: src/word_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;

  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem[rp_q];
  assign o_count = cnt_q;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : word_fifo

// File: testbench/mac_dma_txrx_control_tb.sv
// self-checking bench for the mac dma control block
`timescale 1ns/1ps
module mac_dma_txrx_control_tb
  import dma_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_sof = 1'b0, tx_eof = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] reg_be = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, tx_data = 32'h0000_0000;
  logic [31:0] reg_rdata, mrx_data, rx_data, r, mtx_data;
  logic tx_valid = 1'b0, full_dup = 1'b1, rx_ready = 1'b0, rx_rand = 1'b0;
  logic tx_rdy_s = 1'b0, align_on = 1'b0;
  logic tx_ready, mtx_eof, mtx_valid, mtx_ready, mrx_sof, mrx_eof;
  logic mrx_valid, mrx_ready, rx_valid, rx_shifted, rx_bend;
  logic pause, bpress, running;
  logic [5:0] tx_blen;
  int last_len, frames, n_mismatch = 0, samples_checked = 0, cycles = 0;
  int blens[7] = '{0, 1, 2, 4, 8, 16, 32};
  logic [31:0] rxq[$], rx_got[$], txq[$];
  logic bend_got[$];

  mac_dma_txrx_control mac_dma_txrx_control_inst (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
    .I_REG_ADDR(reg_addr), .I_REG_BE(reg_be), .I_REG_WDATA(reg_wdata),
    .O_REG_RDATA(reg_rdata), .I_TX_DATA(tx_data), .I_TX_SOF(tx_sof),
    .I_TX_EOF(tx_eof), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready),
    .O_MAC_TX_DATA(mtx_data), .O_MAC_TX_SOF(), .O_MAC_TX_EOF(mtx_eof),
    .O_MAC_TX_VALID(mtx_valid), .I_MAC_TX_READY(mtx_ready),
    .I_FULL_DUPLEX(full_dup), .O_PAUSE_REQ(pause), .O_BACKPRESSURE(bpress),
    .O_TX_RUNNING(running), .I_MAC_RX_DATA(mrx_data),
    .I_MAC_RX_SOF(mrx_sof), .I_MAC_RX_EOF(mrx_eof),
    .I_MAC_RX_VALID(mrx_valid), .O_MAC_RX_READY(mrx_ready),
    .O_RX_DATA(rx_data), .O_RX_SOF(), .O_RX_EOF(), .O_RX_VALID(rx_valid),
    .O_RX_SHIFTED(rx_shifted), .O_RX_BURST_END(rx_bend),
    .I_RX_READY(rx_ready), .O_TX_BURST_LEN(tx_blen));

  mac_side_model mac_side_model_inst (
    .i_clk(clk), .i_tx_eof(mtx_eof), .i_tx_valid(mtx_valid),
    .o_tx_ready(mtx_ready), .o_rx_data(mrx_data), .o_rx_sof(mrx_sof),
    .o_rx_eof(mrx_eof), .o_rx_valid(mrx_valid), .i_rx_ready(mrx_ready),
    .o_last_len(last_len), .o_frames(frames));
  //////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(negedge clk) tx_rdy_s <= tx_ready;
  // host side stalls at random while draining
  always @(posedge clk) rx_ready <= rx_rand & ($urandom_range(0, 3) != 0);
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
    if (mtx_valid === 1'b1 && mtx_ready === 1'b1) txq.push_back(mtx_data);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      rx_got.push_back(rx_data);
      bend_got.push_back(rx_bend);
      check("rx shifted", 32'(rx_shifted), 32'(align_on));
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_be <= be;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic send_tx(input int n, input logic s, input logic e);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_valid <= 1'b1;
      // checksum slot of word 7 carries zero from the host
      tx_data <= $urandom() & ((i == 7) ? 32'hFFFF_0000 : 32'hFFFF_FFFF);
      tx_sof <= s && i == 0;
      tx_eof <= e && i == n - 1;
      do @(posedge clk); while (tx_rdy_s !== 1'b1);
      tx_valid <= 1'b0;
    end
  endtask : send_tx
  task automatic wait_frame(input int f0);
    for (int k = 0; k < 400 && frames == f0; k++) @(posedge clk);
  endtask : wait_frame
  task automatic rx_fill(input int b, input logic al, input int n);
    logic [31:0] w;
    wr(OFF_RXC, (32'(b) << BURST_LSB) | (32'(al) << RX_ALIGN_BIT), 4'hF);
    rxq.delete();
    rx_got.delete();
    bend_got.delete();
    align_on = al;
    for (int i = 0; i < n; i++) begin
      w = $urandom();
      rxq.push_back(w);
      mac_side_model_inst.send_rx(w, i == 0, i == n - 1);
    end
  endtask : rx_fill
  task automatic rx_drain(input int b);
    int ne;
    logic [31:0] e;
    logic be;
    ne = align_on ? rxq.size() + 1 : rxq.size();
    rx_rand <= 1'b1;
    for (int k = 0; k < 600 && rx_got.size() < ne; k++) @(posedge clk);
    check("rx count", 32'(rx_got.size()), 32'(ne));
    for (int i = 0; i < rxq.size(); i++) begin
      e = rxq[i];
      if (align_on && i == 0) e = {rxq[0][15:0], 16'h0000};
      if (align_on && i > 0) e = {rxq[i][15:0], rxq[i - 1][31:16]};
      check("rx word", rx_got[i], e);
      be = (i % b == b - 1) || (!align_on && i == rxq.size() - 1);
      if (b > 0) check("burst end", 32'(bend_got[i]), 32'(be));
    end
    if (align_on) check("rx tail", 32'(rx_got[ne - 1][15:0]), 32'(rxq[ne - 2][31:16]));
    rx_rand <= 1'b0;
  endtask : rx_drain
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int n, f0, ex, bl, m;
    void'($urandom(32'h0dd5d797));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    // register resets, reserved bits, byte lanes, unmapped place
    rd(OFF_TXC, r);
    check("txc reset", r, REG_RESET);
    rd(OFF_RXC, r);
    check("rxc reset", r, REG_RESET);
    wr(OFF_RXC, 32'hE0FF_FFFF, 4'hF);
    rd(OFF_RXC, r);
    check("rxc mask", r, RXC_WMASK & 32'hE0FF_FFFF);
    wr(OFF_TXC, 32'hFFFF_FFFF, 4'h1);
    rd(OFF_TXC, r);
    check("txc lane", r, TXC_WMASK & 32'h0000_00FF);
    wr(8'h08, 32'hFFFF_FFFF, 4'hF);
    rd(8'h08, r);
    check("unmapped", r, 32'h0000_0000);
    wr(OFF_TXC, 32'hE0FF_FFFF, 4'hF);
    rd(OFF_TXC, r);
    check("txc mask", r, TXC_WMASK & 32'hE0FF_FFFF);
    $display("test registers done");
    // every pad and crc mode, random lengths and burst fields
    for (int c = 0; c < 8; c++) begin
      m = c % 4;
      bl = blens[$urandom_range(0, 6)];
      wr(OFF_TXC, 32'h1 | (32'(m) << 1) | (32'(bl) << BURST_LSB), 4'hF);
      repeat (3) @(posedge clk);
      check("running", 32'(running), 32'h1);
      check("tx burst", 32'(tx_blen), 32'(bl));
      n = $urandom_range(1, 20);
      ex = (m[1] && n < PAD_TO_WORDS) ? PAD_TO_WORDS : n;
      ex = ex + ((m != 0) ? 1 : 0);
      f0 = frames;
      send_tx(n, 1'b1, 1'b1);
      wait_frame(f0);
      check("tx length", 32'(last_len), 32'(ex));
    end
    $display("test tx modes done");
    // crc append on with checksum generation
    wr(OFF_TXC, 32'h0001_0003, 4'hF);
    txq.delete();
    f0 = frames;
    send_tx(12, 1'b1, 1'b1);
    wait_frame(f0);
    check("csum length", 32'(last_len), 32'd13);
    n = 0;
    for (int i = 3; i < 8; i++) n += txq[i][31:16] + txq[i][15:0];
    n = (n & 32'hFFFF) + (n >> 16);
    n = (n & 32'hFFFF) + (n >> 16);
    check("ip csum", 32'(n), 32'h0000_FFFF);
    $display("test ip checksum done");
    // stop in mid frame waits for the frame end
    f0 = frames;
    send_tx(3, 1'b1, 1'b0);
    wr(OFF_TXC, 32'h0000_0000, 4'hF);
    repeat (4) @(posedge clk);
    check("stopping", 32'(running), 32'h1);
    send_tx(2, 1'b0, 1'b1);
    wait_frame(f0);
    repeat (4) @(posedge clk);
    check("stopped", 32'(running), 32'h0);
    $display("test tx stop done");
    // rx fifo held above high water, flow mode per duplex
    rx_fill(0, 1'b0, 30);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_TXC, 32'(k % 2) << TX_FC_BIT, 4'hF);
      full_dup <= (k >= 2);
      repeat (3) @(posedge clk);
      check("pause", 32'(pause), 32'(k == 3));
      check("backpressure", 32'(bpress), 32'(k == 1));
    end
    rx_drain(0);
    $display("test flow control done");
    for (int k = 1; k < 6; k++) begin
      bl = blens[k];
      rx_fill(bl, k[0], 9);
      rx_drain(bl);
    end
    $display("test rx bursts done");
    end_of_test();
  end
endmodule : mac_dma_txrx_control_tb

// File: testbench/mac_side_model.sv
// mac side model: tx sink with random stalls, rx word source
`timescale 1ns/1ps
module mac_side_model (
  input wire logic i_clk,
  input wire logic i_tx_eof,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [31:0] o_rx_data,
  output logic o_rx_sof,
  output logic o_rx_eof,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output int o_last_len,
  output int o_frames
);
  int cnt = 0;
  logic rdy_s = 1'b0;
  initial begin
    o_tx_ready = 1'b0;
    o_rx_data = 32'h0000_0000;
    o_rx_sof = 1'b0;
    o_rx_eof = 1'b0;
    o_rx_valid = 1'b0;
    o_last_len = 0;
    o_frames = 0;
  end
  //////////////////////////////////////////////////////////////////////////
  // stall one cycle in four so the framer meets back-pressure
  always @(posedge i_clk) begin
    o_tx_ready <= ($urandom_range(0, 3) != 0);
    if (i_tx_valid === 1'b1 && o_tx_ready) begin
      cnt <= (i_tx_eof === 1'b1) ? 0 : cnt + 1;
      if (i_tx_eof === 1'b1) begin
        o_last_len <= cnt + 1;
        o_frames <= o_frames + 1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // ready is registered; sample it mid-cycle to avoid an edge race
  always @(negedge i_clk) rdy_s <= i_rx_ready;
  task automatic send_rx(input logic [31:0] w, input logic s, input logic e);
    @(posedge i_clk);
    o_rx_data <= w;
    o_rx_sof <= s;
    o_rx_eof <= e;
    o_rx_valid <= 1'b1;
    do @(posedge i_clk); while (rdy_s !== 1'b1);
    o_rx_valid <= 1'b0;
    // released data must not look valid
    o_rx_data <= ~w;
  endtask : send_rx
endmodule : mac_side_model
